// file: include/sync_serial_map.vh
// Register map, field positions and reset values of the two-channel serial master port.
// Assumes a 32-bit APB slave on pclk; channel picked by paddr[9].
`ifndef SYNC_SERIAL_MAP_VH
`define SYNC_SERIAL_MAP_VH
`define OFF_STATUS 9'h000
`define OFF_INTPEND 9'h004
`define OFF_INTEN 9'h008
`define OFF_CONFIG 9'h020
`define OFF_ADATA 9'h024
`define OFF_CLKDIV 9'h028
`define OFF_ENABLE 9'h100
`define CH_SEL_BIT 9
`define ST_BUSY 0
`define ST_DONE 1
`define ST_UF 2
`define ST_OF 3
`define ST_BF 4
`define CFG_AO 24
`define CFG_DO 23
`define CFG_ALEN_MSB 22
`define CFG_ALEN_LSB 20
`define CFG_DLEN_MSB 19
`define CFG_DLEN_LSB 16
`define CFG_DD 11
`define CFG_AD 10
`define CFG_BM_MSB 9
`define CFG_BM_LSB 8
`define CFG_CE 7
`define CFG_DP 6
`define CFG_DL 5
`define CFG_EP 4
`define CFG_MASK 32'h01FFFFFF
`define ADATA_DIR 24
`define ADATA_ADDR_LSB 12
`define ADATA_DATA_MSB 11
`define BM_HIGH 2'h0
`define BM_LOW 2'h1
`define RST_WORD 32'h00000000
`define RST_DIV 16'h0000
`endif

// file: rtl/sync_serial_master_port.v
// Two-channel synchronous serial master with APB register access.
// Assumes pclk is the only clock; serial data inputs are asynchronous and synchronised here.
`timescale 1ns/1ps
`include "sync_serial_map.vh"
module sync_serial_master_port (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output wire [1:0] sclk,
	output wire [1:0] transaction_enable_out,
	output wire [1:0] sdata_out,
	output wire [1:0] sdata_out_oe,
	input wire [1:0] sdata_in
);
	localparam [2:0] S_DIR = 3'h0;
	localparam [2:0] S_ADR = 3'h1;
	localparam [2:0] S_TA = 3'h2;
	localparam [2:0] S_DAT = 3'h3;
	localparam [2:0] S_START = 3'h4;
	localparam [2:0] S_END = 3'h5;

	// Next field of a frame
	function [2:0] nxt;
		input [2:0] s;
		input dl;
		input dd;
		input ad;
		input rdf;
		reg [2:0] fa;
		reg [2:0] fb;
		reg ea;
		reg eb;
		begin
			fa = dl ? S_ADR : S_DIR;
			fb = dl ? S_DIR : S_ADR;
			ea = dl ? ~ad : ~dd;
			eb = dl ? ~dd : ~ad;
			if (s == S_START && ea)
				nxt = fa;
			else if ((s == S_START || s == fa) && eb)
				nxt = fb;
			else if (s == S_START || s == fa || s == fb)
				nxt = rdf ? S_TA : S_DAT;
			else if (s == S_TA)
				nxt = S_DAT;
			else
				nxt = S_END;
		end
	endfunction

	reg pready_q;
	reg pslverr_q;
	reg [31:0] prdata_q;
	wire [31:0] ch_rdata [0:1];
	wire [8:0] off = paddr[8:0];
	wire chs = paddr[`CH_SEL_BIT];
	wire setup_done = psel & penable & ~pready_q;
	wire acc = psel & penable & pready_q;
	wire known = off == `OFF_STATUS || off == `OFF_INTPEND || off == `OFF_INTEN || off == `OFF_CONFIG ||
		off == `OFF_ADATA || off == `OFF_CLKDIV || off == `OFF_ENABLE;
	wire hit = known && paddr[11:10] == 2'h0;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= `RST_WORD;
		end else begin
			pready_q <= setup_done;
			if (setup_done) begin
				prdata_q <= (hit && !pwrite) ? ch_rdata[chs] : `RST_WORD;
				pslverr_q <= ~hit;
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : chan
			reg busy_q, done_q, uf_q, of_q, bf_q, en_q;
			reg [3:1] inten_q;
			reg [31:0] cfg_q;
			reg [31:0] adata_q;
			reg [15:0] div_q;
			reg run_q, rd_q, half_q, fin_q;
			reg [2:0] seg_q;
			reg [3:0] cnt_q;
			reg [15:0] ph_q;
			reg [11:0] rx_q;
			reg sclk_q, sen_q, dout_q, oe_q;
			reg din_s1, din_s2;
			reg cell_clk;
			reg bit_val;
			wire sel = hit && chs == g;
			wire wr_c = acc & pwrite & sel;
			wire rd_c = acc & ~pwrite & sel;
			wire w_stat = wr_c && off == `OFF_STATUS;
			wire w_ipend = wr_c && off == `OFF_INTPEND;
			wire w_adata = wr_c && off == `OFF_ADATA;
			wire r_adata = rd_c && off == `OFF_ADATA;
			wire w1c = w_stat | w_ipend;
			wire start = w_adata & ~busy_q & en_q;
			wire [2:0] alen = cfg_q[`CFG_ALEN_MSB:`CFG_ALEN_LSB];
			wire [3:0] dlen = cfg_q[`CFG_DLEN_MSB:`CFG_DLEN_LSB];
			wire [1:0] bm = cfg_q[`CFG_BM_MSB:`CFG_BM_LSB];
			wire [3:0] aidx = cfg_q[`CFG_AO] ? ({1'b0, alen} - cnt_q) : cnt_q;
			wire [3:0] didx = cfg_q[`CFG_DO] ? (dlen - cnt_q) : cnt_q;
			wire [3:0] last = (seg_q == S_ADR) ? {1'b0, alen} : (seg_q == S_DAT) ? dlen : 4'h0;
			wire tick = ph_q == div_q;
			wire [2:0] nseg = nxt(seg_q, cfg_q[`CFG_DL], cfg_q[`CFG_DD], cfg_q[`CFG_AD], rd_q);
			wire released = rd_q && (seg_q == S_TA || seg_q == S_DAT);
			wire [2:0] pend = {of_q, uf_q, done_q} & inten_q;

			// Serial clock level and bit to launch for the current cell
			always @* begin
				cell_clk = cfg_q[`CFG_CE] ^ half_q;
				bit_val = 1'b0;
				case (seg_q)
				S_DIR: begin
					bit_val = ~rd_q ^ cfg_q[`CFG_DP];
				end
				S_ADR: begin
					bit_val = adata_q[`ADATA_ADDR_LSB + aidx];
				end
				S_TA: begin
					if (bm == `BM_HIGH)
						cell_clk = 1'b1;
					else if (bm == `BM_LOW)
						cell_clk = 1'b0;
				end
				S_DAT: begin
					bit_val = adata_q[didx];
				end
				default: begin
					bit_val = 1'b0;
				end
				endcase
			end

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					din_s1 <= 1'b0;
					din_s2 <= 1'b0;
				end else begin
					din_s1 <= sdata_in[g];
					din_s2 <= din_s1;
				end
			end

			// Frame sequencer
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					run_q <= 1'b0;
					rd_q <= 1'b0;
					half_q <= 1'b0;
					fin_q <= 1'b0;
					seg_q <= S_END;
					cnt_q <= 4'h0;
					ph_q <= 16'h0000;
					rx_q <= 12'h000;
				end else begin
					fin_q <= 1'b0;
					if (start) begin
						run_q <= 1'b1;
						rd_q <= ~pwdata[`ADATA_DIR];
						seg_q <= nxt(S_START, cfg_q[`CFG_DL], cfg_q[`CFG_DD], cfg_q[`CFG_AD],
							~pwdata[`ADATA_DIR]);
						cnt_q <= 4'h0;
						half_q <= 1'b0;
						ph_q <= 16'h0000;
						rx_q <= 12'h000;
					end else if (run_q) begin
						ph_q <= tick ? 16'h0000 : ph_q + 16'h0001;
						if (tick) begin
							half_q <= ~half_q;
							if (half_q) begin
								if (seg_q == S_DAT && rd_q)
									rx_q[didx] <= din_s2;
								if (cnt_q == last) begin
									cnt_q <= 4'h0;
									seg_q <= nseg;
									if (nseg == S_END) begin
										run_q <= 1'b0;
										fin_q <= 1'b1;
									end
								end else begin
									cnt_q <= cnt_q + 4'h1;
								end
							end
						end
					end
				end
			end

			// Pin drivers
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sclk_q <= 1'b0;
					sen_q <= 1'b0;
					dout_q <= 1'b0;
					oe_q <= 1'b1;
				end else begin
					sclk_q <= run_q ? cell_clk : cfg_q[`CFG_CE];
					sen_q <= run_q ? ~cfg_q[`CFG_EP] : cfg_q[`CFG_EP];
					oe_q <= ~(run_q & released);
					if (run_q && !released && seg_q != S_TA)
						dout_q <= bit_val;
				end
			end

			// Registers and status
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					busy_q <= 1'b0;
					done_q <= 1'b0;
					uf_q <= 1'b0;
					of_q <= 1'b0;
					bf_q <= 1'b0;
					en_q <= 1'b0;
					inten_q <= 3'h0;
					cfg_q <= `RST_WORD;
					adata_q <= `RST_WORD;
					div_q <= `RST_DIV;
				end else begin
					busy_q <= start | (busy_q & ~fin_q);
					done_q <= fin_q | (done_q & ~(w1c & pwdata[`ST_DONE]));
					of_q <= (w_adata & busy_q) | (of_q & ~(w1c & pwdata[`ST_OF]));
					uf_q <= (r_adata & ~bf_q) | (uf_q & ~(w1c & pwdata[`ST_UF]));
					bf_q <= (fin_q & rd_q) | w_adata | (bf_q & ~((fin_q & ~rd_q) | r_adata));
					if (w_adata && !busy_q)
						adata_q <= pwdata;
					else if (fin_q && rd_q)
						adata_q[`ADATA_DATA_MSB:0] <= rx_q;
					if (wr_c && off == `OFF_INTEN)
						inten_q <= pwdata[3:1];
					if (wr_c && off == `OFF_CONFIG)
						cfg_q <= pwdata & `CFG_MASK;
					if (wr_c && off == `OFF_CLKDIV)
						div_q <= pwdata[15:0];
					if (wr_c && off == `OFF_ENABLE)
						en_q <= pwdata[0];
				end
			end

			assign ch_rdata[g] = (off == `OFF_STATUS) ? {27'h0, bf_q, of_q, uf_q, done_q, busy_q} :
				(off == `OFF_INTPEND) ? {28'h0, pend, 1'b0} :
				(off == `OFF_INTEN) ? {28'h0, inten_q, 1'b0} :
				(off == `OFF_CONFIG) ? cfg_q :
				(off == `OFF_ADATA) ? adata_q :
				(off == `OFF_CLKDIV) ? {16'h0, div_q} :
				(off == `OFF_ENABLE) ? {31'h0, en_q} : `RST_WORD;
			assign sclk[g] = sclk_q;
			assign transaction_enable_out[g] = sen_q;
			assign sdata_out[g] = dout_q;
			assign sdata_out_oe[g] = oe_q;
		end
	endgenerate
endmodule // sync_serial_master_port

// file: tb/serial_peripheral_model.sv
// Peripheral model for one serial channel.
// Assumes enable active high; data launched at rising clock after turnaround.
`timescale 1ns/1ps
module serial_peripheral_model #(parameter [11:0] WORD = 12'hA5C) (
	input wire sclk,
	input wire en,
	input wire oe,
	input wire skip,
	output reg sdi
);
	reg [11:0] sh_q = WORD;
	reg used_q = 1'b0;
	initial sdi = 1'b0;
	always @(posedge sclk or negedge en) begin
		if (!en) begin
			sh_q <= WORD;
			used_q <= 1'b0;
			sdi <= ~sdi;
		end else if (!oe && skip && !used_q) begin
			used_q <= 1'b1;
		end else if (!oe) begin
			sdi <= sh_q[0];
			sh_q <= sh_q >> 1;
		end
	end
endmodule // serial_peripheral_model

// file: tb/sync_serial_master_port_assertions.sv
// Checker of APB answers and serial pin relations.
// Assumes enable polarity 0 and clock idle level 0.
`timescale 1ns/1ps
module sync_serial_master_port_assertions (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire [11:0] paddr,
	input wire pready,
	input wire pslverr,
	input wire [1:0] sclk,
	input wire [1:0] transaction_enable_out,
	input wire [1:0] sdata_out,
	input wire [1:0] sdata_out_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire [1:0] idle = ~transaction_enable_out;
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence answer_s;
		##2 pready;
	endsequence
	apb_answer_a: assert property (setup_s |-> answer_s) else $error("late answer");
	ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
	bad_addr_a: assert property (setup_s and paddr[11:10] != 2'h0 |-> ##2 pslverr) else $error("no error");
	err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
	clk0_static_a: assert property (idle[0] && $past(idle[0]) |-> $stable(sclk[0])) else $error("clock0 moved");
	clk1_static_a: assert property (idle[1] && $past(idle[1]) |-> $stable(sclk[1])) else $error("clock1 moved");
	data_idle_a: assert property (idle[0] && $past(idle[0]) |-> $stable(sdata_out[0])) else $error("data moved");
	oe_frame_a: assert property (!sdata_out_oe[0] |-> transaction_enable_out[0]) else $error("release outside");
endmodule // sync_serial_master_port_assertions
bind sync_serial_master_port sync_serial_master_port_assertions chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .sclk(sclk),
	.transaction_enable_out(transaction_enable_out), .sdata_out(sdata_out), .sdata_out_oe(sdata_out_oe));

// file: tb/sync_serial_master_port_bench.sv
// Bench of the serial master: APB tasks, pin monitor, peripheral models.
// Assumes one wait state per access and clock divider 3.
`timescale 1ns/1ps
`include "sync_serial_map.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; $display("BAD %0t %h %h", $time, a, b); end end
module sync_serial_master_port_bench;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, skip = 0, err, ps = 0, lo = 0;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0, rd, d, bits = 0, cf;
	reg [31:0] cfgs [3] = '{32'h01A70000, 32'h001B0020, 32'h00870C00};
	wire [31:0] prdata;
	wire pready, pslverr;
	wire [1:0] sclk, en, so, oe, si;
	int mismatches = 0, num_checks = 0, nr = 0, c = 0, k, n;
	always #50 pclk = ~pclk;
	sync_serial_master_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
		.transaction_enable_out(en), .sdata_out(so), .sdata_out_oe(oe), .sdata_in(si));
	serial_peripheral_model m0 (.sclk(sclk[0]), .en(en[0]), .oe(oe[0]), .skip(skip), .sdi(si[0]));
	serial_peripheral_model m1 (.sclk(sclk[1]), .en(en[1]), .oe(oe[1]), .skip(skip), .sdi(si[1]));
	always @(posedge pclk) begin
		if (en[c] && sclk[c] && !ps) begin
			nr <= nr + 1;
			bits <= {bits[30:0], so[c]};
		end
		if (!oe[c]) lo <= 1;
		ps <= sclk[c];
	end
	function [11:0] ad(input [8:0] o);
		ad = {2'b00, c[0], o};
	endfunction
	function int nbits(input [31:0] f);
		nbits = !f[11] + (f[10] ? 0 : f[22:20] + 1) + f[19:16] + 1;
	endfunction
	function [31:0] expw(input [31:0] f, input [31:0] w);
		int i;
		begin
			expw = !f[11] && !f[5];
			for (i = 0; i <= f[22:20] && !f[10]; i++) expw = {expw[30:0], w[12 + (f[24] ? f[22:20] - i : i)]};
			if (!f[11] && f[5]) expw = {expw[30:0], 1'b1};
			for (i = 0; i <= f[19:16]; i++) expw = {expw[30:0], w[f[23] ? f[19:16] - i : i]};
		end
	endfunction
	task apb(input w, input [11:0] a, input [31:0] wd);
		begin
			@(posedge pclk);
			psel <= 1;
			pwrite <= w;
			paddr <= a;
			pwdata <= wd;
			@(posedge pclk);
			penable <= 1;
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (pready !== 1'b1 && n < 20);
			if (pready !== 1'b1) mismatches++;
			rd = prdata;
			err = pslverr;
			psel <= 0;
			penable <= 0;
		end
	endtask
	task xfer(input [31:0] f, input [31:0] w, input dbl);
		begin
			apb(1, ad(`OFF_CONFIG), f);
			nr = 0;
			bits = 0;
			lo = 0;
			apb(1, ad(`OFF_ADATA), w);
			if (dbl) apb(1, ad(`OFF_ADATA), ~w);
			apb(0, ad(`OFF_STATUS), 0);
			`CHK(rd[0], 1'b1)
			k = 0;
			while (rd[1] !== 1'b1 && k < 100) begin
				apb(0, ad(`OFF_STATUS), 0);
				k++;
			end
			`CHK(rd[1:0], 2'h2)
			`CHK(rd[4:0], {~w[24], dbl, 3'h2})
		end
	endtask
	task conclude;
		begin
			$display("checks %0d mismatches %0d", num_checks, mismatches);
			if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	initial begin
		#3000000;
		mismatches++;
		conclude;
	end
	initial begin
		void'($urandom(89));
		repeat (8) @(posedge pclk);
		presetn <= 1;
		apb(0, ad(`OFF_STATUS), 0);
		`CHK(rd, 32'h0)
		apb(0, 12'h02C, 0);
		`CHK(err, 1'b1)
		apb(0, 12'hC00, 0);
		`CHK(err, 1'b1)
		for (c = 1; c >= 0; c--) begin
			apb(1, ad(`OFF_ENABLE), 1);
			apb(1, ad(`OFF_CLKDIV), 3);
		end
		for (int t = 0; t < 4; t++) begin
			c = t % 2;
			d = $urandom | 32'h01000000;
			xfer(cfgs[t % 3], d, t == 3);
			`CHK(nr, nbits(cfgs[t % 3]))
			`CHK(bits, expw(cfgs[t % 3], d))
			`CHK(lo, 1'b0)
			apb(1, ad(`OFF_INTEN), 32'hE);
			apb(0, ad(`OFF_INTPEND), 0);
			`CHK(rd, 32'h2 | ((t == 3) << 3))
			apb(1, ad(`OFF_INTPEND), 32'hA);
			apb(0, ad(`OFF_STATUS), 0);
			`CHK(rd, 32'h0)
			$display("write test %0d done", t);
		end
		for (int b = 0; b < 3; b++) begin
			skip <= (b == 2);
			cf = 32'h01270000 | (b << 8);
			xfer(cf, $urandom & 32'h00FFFFFF, 0);
			`CHK(nr, nbits(cf) + (b == 2))
			`CHK(lo, 1'b1)
			apb(0, ad(`OFF_ADATA), 0);
			`CHK(rd[11:0], 12'h05C)
			`CHK(rd[11:8], 4'h0)
			apb(0, ad(`OFF_ADATA), 0);
			apb(0, ad(`OFF_STATUS), 0);
			`CHK(rd[4:0], 5'h06)
			apb(1, ad(`OFF_STATUS), 6);
			$display("read test %0d done", b);
		end
		conclude;
	end
endmodule // sync_serial_master_port_bench
